/* rtl/mss_regs.svh */
// Register map, field positions and reset values of the mode supervisor
`ifndef MSS_REGS_SVH
`define MSS_REGS_SVH
`define MSS_BLK_PAGE 8'h02
`define MSS_NBLK_PAGE 8'h03
`define MSS_OFS_VIE 8'h04
`define MSS_OFS_WSR 8'h14
`define MSS_OFS_OMC 8'h16
`define MSS_VIE_RST 8'h00
`define MSS_OMC_RST 8'h00
`define MSS_VIE_ROV 4
`define MSS_VIE_HT 3
`define MSS_VIE_HV 2
`define MSS_VIE_LV 1
`define MSS_VIE_LB 0
`define MSS_VIE_MSB 4
`define MSS_OMC_MSB 1
`define MSS_SYNC_STAGES 2
`endif

/* rtl/mss_pkg.sv */
// Types shared by the mode and supply supervisor
package mss_pkg;
  typedef enum logic [1:0] {
    MODE_WAKE = 2'b00,
    MODE_STOP = 2'b01,
    MODE_SLEEP = 2'b10,
    MODE_NORMAL = 2'b11
  } mss_mode_t;
  typedef enum logic [2:0] {
    ST_DOWN = 3'b000,
    ST_RAMP = 3'b001,
    ST_NORM = 3'b010,
    ST_STOP = 3'b011,
    ST_SLEEP = 3'b100
  } mss_state_t;
  typedef struct packed {
    logic valid;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mss_bus_req_t;
  typedef struct packed {
    logic ack;
    logic err;
    logic [7:0] rdata;
  } mss_bus_rsp_t;
  typedef struct packed {
    logic io_ok;
    logic core_ok;
    logic [4:0] warn;
    logic [7:0] wake;
  } mss_sense_t;
endpackage

/* rtl/mss_supervisor.sv */
// Operating-mode control, regulator sequencing and warning interrupt gating
`timescale 1ns/1ps
`include "mss_regs.svh"

// Summary of operation
// R01 - Mode code 01 starts Stop transition
// R02 - Mode code 10 enters Sleep, regulators off
// R03 - Code 00 wakes from Stop; 11 is Normal
// R04 - Host reads wake source before next Stop
// R05 - Host waits two clocks after that read
// R06 - Watchdog runs in Normal only, initial period
// R07 - Core regulator enabled after I/O supply good
// R08 - Reset released once core supply good
// R09 - I/O supply low: core off, discharge, reset
// R10 - Bit 4 enables regulator overvoltage interrupt
// R11 - Bit 3 enables high temperature interrupt
// R12 - Bit 2 enables high-side high voltage interrupt
// R13 - Bit 1 enables main supply low voltage interrupt
// R14 - Bit 0 enables low battery interrupt
// R15 - Decode at blocking and non-blocking bases
// R16 - Interrupt only in Normal, held until acknowledged
// R17 - Sleep wake restarts via reset; Stop wake interrupts
// R18 - Warnings raise interrupt only when enabled
module mss_supervisor
  import mss_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire mss_bus_req_t bus_req_i,
  output mss_bus_rsp_t bus_rsp_o,
  input wire mss_sense_t sense_i,
  input wire logic irq_ack_i,
  input wire logic wdog_kick_i,
  output logic io_reg_en_o,
  output logic core_reg_en_o,
  output logic core_dis_o,
  output logic rst_out_n_o,
  output logic irq_o,
  output logic wdog_run_o,
  output logic wdog_init_o,
  output mss_state_t state_o
);

  localparam int SW = $bits(mss_sense_t);

  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  mss_sense_t sns;
  mss_state_t st_ff;
  mss_state_t nxt_st;
  logic [7:0] vie_ff;
  logic [7:0] nxt_vie;
  logic [`MSS_OMC_MSB:0] omc_ff;
  logic [7:0] wsr_ff;
  logic [7:0] nxt_wsr;
  logic armed_ff;
  logic nxt_armed;
  logic [`MSS_VIE_MSB:0] pend_ff;
  logic [`MSS_VIE_MSB:0] nxt_pend;
  logic wake_irq_ff;
  logic nxt_wake_irq;
  logic wdi_ff;
  logic nxt_wdi;
  mss_bus_rsp_t rsp_ff;
  mss_bus_rsp_t nxt_rsp;

  // Two-stage synchroniser for comparator and wake pins
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (ce_i) begin
      sync1_ff <= sense_i;
      sync2_ff <= sync1_ff;
    end
  end
  assign sns = mss_sense_t'(sync2_ff);

  // Address decode on both windows
  wire page_hit = (bus_req_i.addr[15:8] == `MSS_BLK_PAGE)
                | (bus_req_i.addr[15:8] == `MSS_NBLK_PAGE); // [R15]
  wire [7:0] ofs = bus_req_i.addr[7:0];
  wire acc = bus_req_i.valid & page_hit & ce_i;
  wire sel_vie = acc & (ofs == `MSS_OFS_VIE);
  wire sel_wsr = acc & (ofs == `MSS_OFS_WSR);
  wire sel_omc = acc & (ofs == `MSS_OFS_OMC);
  wire mapped = sel_vie | sel_wsr | sel_omc;
  wire vie_wr = sel_vie & bus_req_i.wr;
  wire omc_wr = sel_omc & bus_req_i.wr;
  wire wsr_rd = sel_wsr & ~bus_req_i.wr;
  wire mss_mode_t wsel = mss_mode_t'(bus_req_i.wdata[`MSS_OMC_MSB:0]);
  wire any_wake = |sns.wake;

  // Mode commands
  wire cmd_stop = omc_wr & (wsel == MODE_STOP) & armed_ff; // [R01] [R04]
  wire cmd_sleep = omc_wr & (wsel == MODE_SLEEP); // [R02]
  wire cmd_wake = omc_wr & (wsel == MODE_WAKE); // [R03]

  // Mode and supply sequencing
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_DOWN: begin
        if (sns.io_ok) nxt_st = ST_RAMP; // [R07]
      end
      ST_RAMP: begin
        if (!sns.io_ok) nxt_st = ST_DOWN; // [R09]
        else if (sns.core_ok) nxt_st = ST_NORM; // [R08]
      end
      ST_NORM: begin
        if (!sns.io_ok) nxt_st = ST_DOWN; // [R09]
        else if (cmd_sleep) nxt_st = ST_SLEEP; // [R02]
        else if (cmd_stop) nxt_st = ST_STOP; // [R01]
      end
      ST_STOP: begin
        if (!sns.io_ok) nxt_st = ST_DOWN; // [R09]
        else if (cmd_sleep) nxt_st = ST_SLEEP;
        else if (cmd_wake || any_wake) nxt_st = ST_NORM; // [R03]
      end
      ST_SLEEP: begin
        if (any_wake) nxt_st = ST_DOWN; // [R17]
      end
      default: nxt_st = ST_DOWN;
    endcase
  end

  // Stop re-arm, wake source capture and register writes
  wire stop_woke = (st_ff == ST_STOP) & (nxt_st == ST_NORM);
  wire low_pwr = (st_ff == ST_STOP) | (st_ff == ST_SLEEP);
  // A wake landing in the read cycle keeps Stop disarmed
  assign nxt_armed = stop_woke ? 1'b0 : (wsr_rd ? 1'b1 : armed_ff); // [R04]
  assign nxt_wsr = (wsr_rd ? 8'h00 : wsr_ff) | (low_pwr ? sns.wake : 8'h00);
  assign nxt_vie = vie_wr ? {3'h0, bus_req_i.wdata[`MSS_VIE_MSB:0]} : vie_ff;

  // Sticky warning flags, set wins over acknowledge
  wire [`MSS_VIE_MSB:0] warn_en = sns.warn & vie_ff[`MSS_VIE_MSB:0]; // [R10] [R11] [R12] [R13] [R14] [R18]
  assign nxt_pend = (irq_ack_i ? 5'h00 : pend_ff) | warn_en;
  assign nxt_wake_irq = stop_woke | (wake_irq_ff & ~irq_ack_i); // [R17]

  // Watchdog initial period runs from Normal entry until first kick
  wire enter_norm = (st_ff != ST_NORM) & (nxt_st == ST_NORM);
  assign nxt_wdi = enter_norm | (wdi_ff & ~wdog_kick_i & (st_ff == ST_NORM)); // [R06]

  // Read mux and response
  wire [7:0] rd_mux = sel_vie ? vie_ff
                    : sel_wsr ? wsr_ff
                    : sel_omc ? {6'h00, omc_ff} : 8'h00;
  assign nxt_rsp.ack = acc;
  assign nxt_rsp.err = acc & ~mapped;
  assign nxt_rsp.rdata = bus_req_i.wr ? 8'h00 : rd_mux;

  // State registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_ff <= ST_DOWN;
      vie_ff <= `MSS_VIE_RST; // [R18]
      omc_ff <= '0;
      wsr_ff <= 8'h00;
      armed_ff <= 1'b1;
      pend_ff <= '0;
      wake_irq_ff <= 1'b0;
      wdi_ff <= 1'b0;
      rsp_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
      vie_ff <= nxt_vie;
      if (omc_wr) omc_ff <= bus_req_i.wdata[`MSS_OMC_MSB:0];
      wsr_ff <= nxt_wsr;
      armed_ff <= nxt_armed;
      pend_ff <= nxt_pend;
      wake_irq_ff <= nxt_wake_irq;
      wdi_ff <= nxt_wdi;
      rsp_ff <= nxt_rsp;
    end
  end

  // Outputs decoded from the mode state
  wire norm = (st_ff == ST_NORM);
  assign io_reg_en_o = (st_ff != ST_SLEEP); // [R02]
  assign core_reg_en_o = (st_ff == ST_RAMP) | norm | (st_ff == ST_STOP); // [R07]
  assign core_dis_o = ~core_reg_en_o; // [R09]
  assign rst_out_n_o = norm | (st_ff == ST_STOP); // [R08] [R09]
  assign irq_o = norm & ((|pend_ff) | wake_irq_ff); // [R16]
  assign wdog_run_o = norm; // [R06]
  assign wdog_init_o = wdi_ff & norm;
  assign state_o = st_ff;
  assign bus_rsp_o = rsp_ff;

  // Checks on mode, supply and interrupt behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_stop_entry: assert property ( // [R01]
    (norm && sns.io_ok && !cmd_sleep && omc_wr && wsel == MODE_STOP && armed_ff)
    |=> (st_ff == ST_STOP) && core_reg_en_o && rst_out_n_o)
    else $error("stop command not taken");
  a_sleep_entry: assert property ( // [R02]
    (norm && sns.io_ok && cmd_sleep) |=> !io_reg_en_o && !core_reg_en_o)
    else $error("sleep did not switch regulators off");
  a_stop_wake: assert property ( // [R03]
    ((st_ff == ST_STOP) && sns.io_ok && !cmd_sleep && cmd_wake) |=> norm)
    else $error("wake code did not leave stop");
  a_stop_unarmed: assert property ( // [R04]
    (norm && ce_i && !armed_ff && !wsr_rd) |=> (st_ff != ST_STOP))
    else $error("stop taken without wake source read");
  a_wdog_init: assert property ( // [R06]
    $rose(wdog_run_o) |-> wdog_init_o)
    else $error("watchdog started without initial period");
  a_core_order: assert property ( // [R07]
    $rose(core_reg_en_o) |-> $past(sns.io_ok))
    else $error("core regulator enabled before io supply");
  a_rst_release: assert property ( // [R08]
    $rose(rst_out_n_o) |-> $past(sns.core_ok) || $past(st_ff) == ST_NORM)
    else $error("reset released before core supply");
  a_pwr_down: assert property ( // [R09]
    (ce_i && !sns.io_ok && core_reg_en_o)
    |=> !core_reg_en_o && core_dis_o && !rst_out_n_o)
    else $error("power-down sequence missed");
  a_irq_gate: assert property ( // [R10] [R11] [R12] [R13] [R14] [R18]
    ((pend_ff & ~$past(pend_ff)) & ~$past(vie_ff[`MSS_VIE_MSB:0])) == 5'h00)
    else $error("disabled warning raised a flag");
  a_irq_mode: assert property ( // [R16]
    irq_o |-> norm)
    else $error("interrupt outside normal");
  a_irq_hold: assert property ( // [R16]
    (irq_o && !irq_ack_i && ce_i) |=> irq_o || !norm)
    else $error("interrupt dropped before acknowledge");
  a_pend_hold: assert property ( // [R16]
    (ce_i && !irq_ack_i) |=> (pend_ff & $past(pend_ff)) == $past(pend_ff))
    else $error("warning flag lost without acknowledge");
  a_sleep_wake: assert property ( // [R17]
    ((st_ff == ST_SLEEP) && ce_i && any_wake) |=> (st_ff == ST_DOWN) ##1 !rst_out_n_o)
    else $error("sleep wake did not go through reset");
  a_addr_decode: assert property ( // [R15]
    (bus_req_i.valid && ce_i && !page_hit) |=> !bus_rsp_o.ack)
    else $error("access outside windows answered");

  // Bus answer and register write checks
  a_rsp_ack: assert property ( // [R15]
    acc |=> bus_rsp_o.ack)
    else $error("taken access not answered");
  a_rsp_err: assert property ( // [R15]
    (acc && !mapped) |=> bus_rsp_o.ack && bus_rsp_o.err)
    else $error("unmapped offset answered without error");
  a_vie_write: assert property ( // [R10] [R11] [R12] [R13] [R14]
    vie_wr |=> vie_ff == {3'h0, $past(bus_req_i.wdata[`MSS_VIE_MSB:0])})
    else $error("enable register write lost");

  // Each disabled warning keeps its flag clear
  a_rov_gate: assert property ( // [R10]
    (ce_i && !vie_ff[`MSS_VIE_ROV] && !pend_ff[`MSS_VIE_ROV])
    |=> !pend_ff[`MSS_VIE_ROV])
    else $error("overvoltage flag set while disabled");
  a_ht_gate: assert property ( // [R11]
    (ce_i && !vie_ff[`MSS_VIE_HT] && !pend_ff[`MSS_VIE_HT])
    |=> !pend_ff[`MSS_VIE_HT])
    else $error("high temperature flag set while disabled");
  a_hv_gate: assert property ( // [R12]
    (ce_i && !vie_ff[`MSS_VIE_HV] && !pend_ff[`MSS_VIE_HV])
    |=> !pend_ff[`MSS_VIE_HV])
    else $error("high voltage flag set while disabled");
  a_lv_gate: assert property ( // [R13]
    (ce_i && !vie_ff[`MSS_VIE_LV] && !pend_ff[`MSS_VIE_LV])
    |=> !pend_ff[`MSS_VIE_LV])
    else $error("low voltage flag set while disabled");
  a_lb_gate: assert property ( // [R14]
    (ce_i && !vie_ff[`MSS_VIE_LB] && !pend_ff[`MSS_VIE_LB])
    |=> !pend_ff[`MSS_VIE_LB])
    else $error("low battery flag set while disabled");

  // Mode and supply output checks
  a_sleep_regs: assert property ( // [R02]
    (st_ff == ST_SLEEP) |-> !io_reg_en_o && !core_reg_en_o)
    else $error("regulator on in sleep");
  a_code_normal: assert property ( // [R03]
    (norm && sns.io_ok && omc_wr && wsel == MODE_NORMAL) |=> norm)
    else $error("normal code left normal mode");
  a_wake_in_norm: assert property ( // [R03]
    (norm && sns.io_ok && omc_wr && wsel == MODE_WAKE) |=> norm)
    else $error("wake code acted outside stop");
  a_wdog_mode: assert property ( // [R06]
    !norm |-> !wdog_run_o && !wdog_init_o)
    else $error("watchdog active outside normal");
  a_rst_down: assert property ( // [R09]
    (st_ff == ST_DOWN) |-> !rst_out_n_o && core_dis_o && !core_reg_en_o)
    else $error("reset or discharge missing while down");
  a_wake_irq: assert property ( // [R17]
    ((st_ff == ST_STOP) && ce_i && sns.io_ok && !cmd_sleep && any_wake)
    |=> norm && irq_o)
    else $error("stop wake not signalled");
  a_armed_drop: assert property ( // [R04]
    (stop_woke && ce_i) |=> !armed_ff)
    else $error("stop still armed after wake");
  a_wsr_capture: assert property ( // [R04]
    (low_pwr && ce_i && any_wake) |=> |wsr_ff)
    else $error("wake source not captured");
  a_ce_freeze: assert property (
    !ce_i |=> $stable(st_ff) && $stable(vie_ff) && $stable(pend_ff))
    else $error("state moved while clock enable low");

  c_stop_cycle: cover property (norm ##1 (st_ff == ST_STOP) ##[1:20] irq_o);
  c_sleep_wake: cover property ((st_ff == ST_SLEEP) ##[1:20] (st_ff == ST_RAMP));
  c_warn_irq: cover property ($rose(|pend_ff) ##0 irq_o);
  c_unarmed: cover property (norm && omc_wr && wsel == MODE_STOP && !armed_ff);

endmodule

/* test/mss_host.sv */
// Host model of the die link register bus
`timescale 1ns/1ps
module mss_host
  import mss_pkg::*;
(
  input wire logic sys_clk_i,
  input wire mss_bus_rsp_t bus_rsp_i,
  output mss_bus_req_t bus_req_o
);
  mss_bus_rsp_t rsp_q;
  logic wsr_rd_q;
  initial begin
    bus_req_o = '0;
    rsp_q = '0;
    wsr_rd_q = 1'b0;
  end
  // One access; the answer is taken once the ack edge has landed
  task automatic xfer(input logic wr, input logic [15:0] adr, input logic [7:0] wd);
    if (wr && adr[7:0] == 8'h16 && wsr_rd_q) begin
      repeat (2) @(posedge sys_clk_i);
    end
    @(posedge sys_clk_i);
    bus_req_o <= '{valid: 1'b1, wr: wr, addr: adr, wdata: wd};
    @(posedge sys_clk_i);
    bus_req_o <= '{valid: 1'b0, wr: ~wr, addr: ~adr, wdata: ~wd};
    #1 rsp_q = bus_rsp_i;
    wsr_rd_q = !wr && adr[7:0] == 8'h14;
  endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the mode and supply supervisor
`timescale 1ns/1ps
module testbench;
  import mss_pkg::*;
  typedef struct packed {
    logic wr;
    logic [15:0] adr;
    logic [7:0] wd;
    logic [9:0] rsp;
  } mss_row_t;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ack_i = 1'b0;
  logic kick_i = 1'b0;
  mss_sense_t sense_i = '0;
  mss_bus_req_t req;
  mss_bus_rsp_t rsp;
  logic io_en, core_en, dis, rstn, irq, run, winit;
  mss_state_t st;
  int fail_count = 0;
  int checks_done = 0;
  // Register accesses: write, address, data, {ack, err, rdata}
  mss_row_t rows [8] = '{'{1'b0, 16'h0204, 8'h00, 10'h200}, '{1'b1, 16'h0204, 8'hFF, 10'h200},
    '{1'b0, 16'h0304, 8'h00, 10'h21F}, '{1'b1, 16'h0304, 8'h00, 10'h200},
    '{1'b0, 16'h0210, 8'h00, 10'h300}, '{1'b1, 16'h0216, 8'h03, 10'h200},
    '{1'b0, 16'h0316, 8'h00, 10'h203}, '{1'b0, 16'h0404, 8'h00, 10'h000}};
  wire logic [15:0] obs = {7'h00, st, io_en, core_en, dis, rstn, irq, run};
  always #25 sys_clk_i = ~sys_clk_i;
  mss_supervisor mss_supervisor_i(.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .bus_req_i(req), .bus_rsp_o(rsp), .sense_i(sense_i), .irq_ack_i(ack_i),
    .wdog_kick_i(kick_i), .io_reg_en_o(io_en), .core_reg_en_o(core_en), .core_dis_o(dis),
    .rst_out_n_o(rstn), .irq_o(irq), .wdog_run_o(run), .wdog_init_o(winit), .state_o(st));
  mss_host mss_host_i(.sys_clk_i(sys_clk_i), .bus_rsp_i(rsp), .bus_req_o(req));
  function automatic logic [15:0] o(input mss_state_t s, input logic [5:0] b);
    return {7'h00, s, b};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wait_st(input mss_state_t s);
    for (int i = 0; i < 12 && st !== s; i++) cyc(1);
  endtask
  task automatic pulse_ack();
    @(posedge sys_clk_i) ack_i <= 1'b1;
    @(posedge sys_clk_i) ack_i <= 1'b0;
    #1 chk({15'h0000, irq}, 16'h0000);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    cyc(4000);
    fail_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk_i);
    @(posedge sys_clk_i) rst_i <= 1'b0;
    cyc(1);
    chk(obs, o(ST_DOWN, 6'b101000));
    @(posedge sys_clk_i) sense_i.io_ok <= 1'b1;
    wait_st(ST_RAMP);
    chk(obs, o(ST_RAMP, 6'b110000));
    @(posedge sys_clk_i) sense_i.core_ok <= 1'b1;
    wait_st(ST_NORM);
    chk(obs, o(ST_NORM, 6'b110101));
    chk({15'h0000, winit}, 16'h0001);
    @(posedge sys_clk_i) kick_i <= 1'b1;
    @(posedge sys_clk_i) kick_i <= 1'b0;
    #1 chk({15'h0000, winit}, 16'h0000);
    $display("power-up done");
    foreach (rows[i]) begin
      mss_host_i.xfer(rows[i].wr, rows[i].adr, rows[i].wd);
      chk({6'h00, mss_host_i.rsp_q}, {6'h00, rows[i].rsp});
    end
    chk(obs, o(ST_NORM, 6'b110101));
    $display("register table done");
    for (int b = 0; b < 5; b++) begin
      mss_host_i.xfer(1'b1, 16'h0204, 8'h01 << b);
      @(posedge sys_clk_i) sense_i.warn <= 5'h1F ^ (5'h01 << b);
      cyc(5);
      chk({15'h0000, irq}, 16'h0000);
      @(posedge sys_clk_i) sense_i.warn <= 5'h01 << b;
      cyc(5);
      chk({15'h0000, irq}, 16'h0001);
      @(posedge sys_clk_i) sense_i.warn <= 5'h00;
      cyc(5);
      chk({15'h0000, irq}, 16'h0001);
      pulse_ack();
    end
    $display("interrupt gating done");
    mss_host_i.xfer(1'b1, 16'h0216, 8'h01);
    chk(obs, o(ST_STOP, 6'b110100));
    @(posedge sys_clk_i) sense_i.warn <= 5'h10;
    cyc(5);
    chk({15'h0000, irq}, 16'h0000);
    @(posedge sys_clk_i) sense_i.warn <= 5'h00;
    mss_host_i.xfer(1'b1, 16'h0316, 8'h00);
    chk(obs, o(ST_NORM, 6'b110111));
    pulse_ack();
    mss_host_i.xfer(1'b1, 16'h0216, 8'h01);
    chk(obs, o(ST_NORM, 6'b110101));
    mss_host_i.xfer(1'b0, 16'h0214, 8'h00);
    mss_host_i.xfer(1'b1, 16'h0216, 8'h01);
    chk(obs, o(ST_STOP, 6'b110100));
    @(posedge sys_clk_i) sense_i.wake <= 8'h01;
    wait_st(ST_NORM);
    chk(obs, o(ST_NORM, 6'b110111));
    @(posedge sys_clk_i) sense_i.wake <= 8'h00;
    pulse_ack();
    mss_host_i.xfer(1'b0, 16'h0214, 8'h00);
    chk({6'h00, mss_host_i.rsp_q}, 16'h0201);
    $display("stop mode done");
    mss_host_i.xfer(1'b1, 16'h0216, 8'h02);
    chk({11'h000, st, io_en, core_en}, {11'h000, ST_SLEEP, 2'b00});
    @(posedge sys_clk_i) sense_i.wake <= 8'h01;
    wait_st(ST_DOWN);
    chk(obs, o(ST_DOWN, 6'b101000));
    @(posedge sys_clk_i) sense_i.wake <= 8'h00;
    wait_st(ST_NORM);
    chk(obs, o(ST_NORM, 6'b110101));
    $display("sleep mode done");
    @(posedge sys_clk_i) sense_i.io_ok <= 1'b0;
    wait_st(ST_DOWN);
    chk(obs, o(ST_DOWN, 6'b101000));
    $display("power-down done");
    mss_host_i.xfer(1'b1, 16'h0204, 8'h1F);
    @(posedge sys_clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    @(posedge sys_clk_i) rst_i <= 1'b0;
    cyc(1);
    chk(obs, o(ST_DOWN, 6'b101000));
    mss_host_i.xfer(1'b0, 16'h0204, 8'h00);
    chk({6'h00, mss_host_i.rsp_q}, 16'h0200);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule
